/* core/bsr_core.sv */
`timescale 1ns/1ns
`default_nettype none
module bsr_core
  import bsr_pkg::*;
#(
  parameter int NUM_INST   = BSR_INST_MAX,
  parameter int FIFO_DEPTH = BSR_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic                         clk,
  input  wire logic                         rst_n,
  // Scan samples from the user logic
  input  wire logic                         scan_valid,
  output logic                              scan_ready,
  input  wire logic [BSR_INST_W-1:0]        scan_inst,
  input  wire logic                         block_activate_coil,
  input  wire logic                         field_wipe_coil,
  input  wire logic                         forward_shift_pulse,
  input  wire logic                         backward_shift_pulse,
  input  wire logic                         forward_bit_input,
  input  wire logic                         backward_bit_input,
  input  wire logic signed [BSR_WORD_W-1:0] forward_word_input,
  input  wire logic signed [BSR_WORD_W-1:0] backward_word_input,
  // Mode setting
  input  wire logic                         mode_set,
  input  wire logic [BSR_INST_W-1:0]        mode_set_inst,
  input  wire logic                         double_word_mode,
  // Scan results
  output logic                              res_valid,
  input  wire logic                         res_ready,
  output logic [BSR_INST_W-1:0]             res_inst,
  output logic                              res_word_mode,
  output logic [BSR_FIELDS-1:0]             bit_field_outputs,
  output logic [BSR_FLAT_W-1:0]             word_field_outputs,
  output logic                              word_outputs_live
);

  // ****************************************************************
  // Parameter checks
  // ****************************************************************
  generate
    if (NUM_INST < 1 || NUM_INST > BSR_INST_MAX) begin : g_bad_inst // [RULE10]
      $error("bsr_core instance count must lie between one and thirty-two");
    end
  endgenerate

  // ****************************************************************
  // Helpers
  // ****************************************************************

  // Bit zero of every field, field one in the lowest position.
  function automatic logic [BSR_FIELDS-1:0] bits_of(input logic [BSR_FLAT_W-1:0] flat);
    logic [BSR_FIELDS-1:0] b;
    b = '0;
    for (int i = 0; i < BSR_FIELDS; i++) begin
      b[i] = flat[i*BSR_WORD_W];
    end
    return b;
  endfunction : bits_of

  // Bit fields as zero-extended words, so stale word data never leaks into bit mode.
  function automatic logic [BSR_FLAT_W-1:0] widen(input logic [BSR_FIELDS-1:0] b);
    logic [BSR_FLAT_W-1:0] w;
    w = '0;
    for (int i = 0; i < BSR_FIELDS; i++) begin
      w[i*BSR_WORD_W] = b[i];
    end
    return w;
  endfunction : widen

  // ****************************************************************
  // Scan queue
  // ****************************************************************
  logic [BSR_SCAN_W-1:0] in_word;
  logic [BSR_SCAN_W-1:0] q_word;
  logic                  q_valid;
  logic                  q_ready;

  assign in_word = {scan_inst, backward_bit_input, forward_bit_input, backward_shift_pulse,
                    forward_shift_pulse, field_wipe_coil, block_activate_coil,
                    backward_word_input, forward_word_input};

  // The queue lets the user logic run ahead of result consumption; a stalled result
  // port fills it and then pulls scan_ready low.
  bsr_fifo #(
    .WIDTH (BSR_SCAN_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (scan_valid),
    .in_ready  (scan_ready),
    .in_data   (in_word),
    .out_valid (q_valid),
    .out_ready (q_ready),
    .out_data  (q_word)
  );

  // ****************************************************************
  // Decode of the sample at the head of the queue
  // ****************************************************************
  logic [BSR_INST_W-1:0] inst;
  logic                  inst_ok;
  logic                  pop;
  logic                  act;
  logic                  wipe;
  logic                  fwd_bit;
  logic                  bwd_bit;
  logic [BSR_WORD_W-1:0] fwd_word;
  logic [BSR_WORD_W-1:0] bwd_word;
  logic                  fwd_rise;
  logic                  bwd_rise;
  logic                  wmode;
  logic                  res_valid_r;

  assign inst     = q_word[BSR_POS_INST +: BSR_INST_W];
  assign inst_ok  = (32'(inst) < NUM_INST);
  assign act      = q_word[BSR_POS_ACT];
  assign wipe     = q_word[BSR_POS_WIPE];
  assign fwd_bit  = q_word[BSR_POS_FWD_BIT];
  assign bwd_bit  = q_word[BSR_POS_BWD_BIT];
  assign fwd_word = q_word[BSR_POS_FWD_WORD +: BSR_WORD_W];
  assign bwd_word = q_word[BSR_POS_BWD_WORD +: BSR_WORD_W];

  // One sample is evaluated per clock whenever the result stage is free.
  assign q_ready = ~res_valid_r | res_ready;
  assign pop     = q_valid & q_ready;

  bsr_edge #(
    .NUM_INST (NUM_INST)
  ) u_edge (
    .clk      (clk),
    .rst_n    (rst_n),
    .upd      (pop & inst_ok),
    .upd_inst (inst),
    .fwd_lvl  (q_word[BSR_POS_FWD_LVL]),
    .bwd_lvl  (q_word[BSR_POS_BWD_LVL]),
    .fwd_rise (fwd_rise),
    .bwd_rise (bwd_rise)
  );

  // ****************************************************************
  // Per-instance state
  // ****************************************************************
  bsr_mode_t             mode_r [NUM_INST];
  logic [BSR_FLAT_W-1:0] fld_r  [NUM_INST];
  logic [BSR_FLAT_W-1:0] cur_flat;
  logic [BSR_FLAT_W-1:0] fld_nxt;
  logic [BSR_WORD_W-1:0] load_fwd;
  logic [BSR_WORD_W-1:0] load_bwd;

  assign wmode    = inst_ok && (mode_r[inst] == BSR_MODE_WORD);
  // Bit mode sees only the low bit of each field and never the word inputs.
  assign cur_flat = !inst_ok ? '0 : (wmode ? fld_r[inst] : widen(bits_of(fld_r[inst]))); // [RULE9]
  assign load_fwd = wmode ? fwd_word : {{(BSR_WORD_W-1){1'b0}}, fwd_bit}; // [RULE7] [RULE9]
  assign load_bwd = wmode ? bwd_word : {{(BSR_WORD_W-1){1'b0}}, bwd_bit}; // [RULE7] [RULE9]

  // Next contents of the addressed instance. The wipe is checked before the shifts, so it beats a
  // shift in the same scan; forward beats backward when both edges coincide.
  always_comb begin
    fld_nxt = cur_flat;
    if (!act) begin
      fld_nxt = cur_flat; // [RULE6]
    end else if (wipe) begin
      fld_nxt = '0; // [RULE5] [RULE14]
    end else if (fwd_rise) begin
      fld_nxt = {cur_flat[BSR_FLAT_W-BSR_WORD_W-1:0], load_fwd}; // [RULE2] [RULE11]
    end else if (bwd_rise) begin
      fld_nxt = {load_bwd, cur_flat[BSR_FLAT_W-1:BSR_WORD_W]}; // [RULE3] [RULE12]
    end
  end

  // Mode setting per instance; bit operation after reset.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_INST; i++) begin
        mode_r[i] <= BSR_MODE_RESET; // [RULE1]
      end
    end else if (mode_set && 32'(mode_set_inst) < NUM_INST) begin
      mode_r[mode_set_inst] <= double_word_mode ? BSR_MODE_WORD : BSR_MODE_BIT; // [RULE1]
    end
  end

  // Field storage, one set of eight per instance.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_INST; i++) begin
        fld_r[i] <= '0;
      end
    end else if (pop && inst_ok) begin
      fld_r[inst] <= fld_nxt; // [RULE10]
    end
  end

  // ****************************************************************
  // Result stage
  // ****************************************************************
  logic [BSR_INST_W-1:0] res_inst_r;
  logic                  res_wmode_r;
  logic [BSR_FLAT_W-1:0] res_fld_r;
  logic [BSR_FIELDS-1:0] bit_out_r;
  logic [BSR_FLAT_W-1:0] word_out_r;
  logic                  word_live_r;

  // Valid holds until taken; samples for absent instances are dropped silently.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      res_valid_r <= 1'b0;
    end else if (pop && inst_ok) begin
      res_valid_r <= 1'b1;
    end else if (res_ready) begin
      res_valid_r <= 1'b0;
    end
  end

  // Result fields follow the new contents of the evaluated instance.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      res_inst_r  <= '0;
      res_wmode_r <= 1'b0;
      res_fld_r   <= '0;
      bit_out_r   <= '0;
      word_out_r  <= '0;
      word_live_r <= 1'b0;
    end else if (pop && inst_ok) begin
      res_inst_r  <= inst;
      res_wmode_r <= wmode;
      res_fld_r   <= fld_nxt;
      bit_out_r   <= wmode ? '0 : bits_of(fld_nxt); // [RULE4]
      word_out_r  <= wmode ? fld_nxt : '0; // [RULE8] [RULE9]
      word_live_r <= wmode; // [RULE8]
    end
  end

  assign res_valid          = res_valid_r;
  assign res_inst           = res_inst_r;
  assign res_word_mode      = res_wmode_r;
  assign bit_field_outputs  = bit_out_r;
  assign word_field_outputs = word_out_r;
  assign word_outputs_live  = word_live_r;

  // ****************************************************************
  // Checks
  // ****************************************************************
  logic                  take;
  logic [BSR_FIELDS-1:0] cur_bits;
  logic [BSR_FIELDS-2:0] cur_bits_lo;
  logic [BSR_FIELDS-2:0] cur_bits_hi;
  logic [BSR_FLAT_W-BSR_WORD_W-1:0] cur_lo;
  logic [BSR_FLAT_W-BSR_WORD_W-1:0] cur_hi;

  assign take        = pop && inst_ok;
  assign cur_bits    = bits_of(cur_flat);
  assign cur_bits_lo = cur_bits[BSR_FIELDS-2:0];
  assign cur_bits_hi = cur_bits[BSR_FIELDS-1:1];
  assign cur_lo      = cur_flat[BSR_FLAT_W-BSR_WORD_W-1:0];
  assign cur_hi      = cur_flat[BSR_FLAT_W-1:BSR_WORD_W];

  sequence s_live_shift;
    take && act && !wipe;
  endsequence

  sequence s_fwd_bit;
    s_live_shift ##0 (fwd_rise && !wmode);
  endsequence

  sequence s_bwd_bit;
    s_live_shift ##0 (!fwd_rise && bwd_rise && !wmode);
  endsequence

  sequence s_fwd_word;
    s_live_shift ##0 (fwd_rise && wmode);
  endsequence

  sequence s_bwd_word;
    s_live_shift ##0 (!fwd_rise && bwd_rise && wmode);
  endsequence

  chk_bit_fwd_shift: assert property (@(posedge clk) disable iff (!rst_n) // [RULE2]
    s_fwd_bit |=> res_valid && bit_field_outputs == {$past(cur_bits_lo), $past(fwd_bit)})
    else $error("bit forward shift wrong");

  chk_bit_bwd_shift: assert property (@(posedge clk) disable iff (!rst_n) // [RULE3]
    s_bwd_bit |=> res_valid && bit_field_outputs == {$past(bwd_bit), $past(cur_bits_hi)})
    else $error("bit backward shift wrong");

  chk_word_fwd_shift: assert property (@(posedge clk) disable iff (!rst_n) // [RULE11]
    s_fwd_word |=> word_field_outputs == {$past(cur_lo), $past(fwd_word)})
    else $error("word forward shift wrong");

  chk_word_bwd_shift: assert property (@(posedge clk) disable iff (!rst_n) // [RULE12]
    s_bwd_word |=> word_field_outputs == {$past(bwd_word), $past(cur_hi)})
    else $error("word backward shift wrong");

  chk_wipe_wins_zero: assert property (@(posedge clk) disable iff (!rst_n) // [RULE14]
    take && act && wipe |=> res_fld_r == '0 && bit_field_outputs == '0)
    else $error("wipe did not clear all fields");

  chk_idle_fields_hold: assert property (@(posedge clk) disable iff (!rst_n) // [RULE6]
    take && !act |=> res_fld_r == $past(cur_flat))
    else $error("inactive instance changed its fields");

  chk_bit_words_quiet: assert property (@(posedge clk) disable iff (!rst_n) // [RULE9]
    res_valid && !res_word_mode |-> word_field_outputs == '0 && !word_outputs_live)
    else $error("word outputs driven in bit mode");

  chk_word_out_mirror: assert property (@(posedge clk) disable iff (!rst_n) // [RULE8]
    res_valid && res_word_mode |-> word_field_outputs == res_fld_r && bit_field_outputs == '0)
    else $error("word outputs do not mirror fields");

  chk_result_holds: assert property (@(posedge clk) disable iff (!rst_n) // [RULE4]
    res_valid && !res_ready |=> res_valid && $stable(bit_field_outputs) && $stable(res_inst))
    else $error("result changed while stalled");

endmodule : bsr_core
`default_nettype wire

/* core/bsr_edge.sv */
`timescale 1ns/1ns
`default_nettype none
module bsr_edge
  import bsr_pkg::*;
#(
  parameter int NUM_INST = BSR_INST_MAX
) (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  // Scan being evaluated
  input  wire logic                  upd,
  input  wire logic [BSR_INST_W-1:0] upd_inst,
  input  wire logic                  fwd_lvl,
  input  wire logic                  bwd_lvl,
  // Edges found in this scan
  output logic                       fwd_rise,
  output logic                       bwd_rise
);

  logic [NUM_INST-1:0] fwd_prev_r;
  logic [NUM_INST-1:0] bwd_prev_r;

  // A pulse counts once: high now and low on the previous scan of the same instance.
  assign fwd_rise = fwd_lvl & ~fwd_prev_r[upd_inst]; // [RULE13]
  assign bwd_rise = bwd_lvl & ~bwd_prev_r[upd_inst]; // [RULE13]

  // Levels are remembered on every scan, active or not, so a coil held high while the
  // block is switched on does not fire a late shift.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fwd_prev_r <= {NUM_INST{BSR_LVL_RESET}};
      bwd_prev_r <= {NUM_INST{BSR_LVL_RESET}};
    end else if (upd) begin
      fwd_prev_r[upd_inst] <= fwd_lvl; // [RULE13]
      bwd_prev_r[upd_inst] <= bwd_lvl;
    end
  end

  chk_edge_held_level: assert property (@(posedge clk) disable iff (!rst_n) // [RULE13]
    upd ##1 (upd && $past(upd_inst) == upd_inst && $past(fwd_lvl) && fwd_lvl) |-> !fwd_rise)
    else $error("held forward level produced a second edge");

endmodule : bsr_edge
`default_nettype wire

/* core/bsr_fifo.sv */
`timescale 1ns/1ns
`default_nettype none
module bsr_fifo
  import bsr_pkg::*;
#(
  parameter int WIDTH = BSR_SCAN_W,
  parameter int DEPTH = BSR_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

  // ****************************************************************
  // Storage
  // ****************************************************************
  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("bsr_fifo depth must be a power of two of at least two");
    end
  endgenerate

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW-1:0]    wr_ptr_r;
  logic [PW-1:0]    rd_ptr_r;
  logic [CW-1:0]    count_r;
  logic [CW-1:0]    count_nxt;
  logic             full_r;
  logic             push;
  logic             pop;

  // Full is kept as its own flop so that the ready seen by the source is registered.
  assign in_ready  = ~full_r;
  assign out_valid = (count_r != '0);
  assign out_data  = mem_r[rd_ptr_r];
  assign push      = in_valid & ~full_r;
  assign pop       = out_valid & out_ready;

  // Occupancy follows pushes and pops.
  always_comb begin
    count_nxt = count_r;
    if (push && !pop) begin
      count_nxt = count_r + CW'(1);
    end else if (pop && !push) begin
      count_nxt = count_r - CW'(1);
    end
  end

  // Pointers, count and full flag.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
      full_r   <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + PW'(1);
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + PW'(1);
      end
      count_r <= count_nxt;
      full_r  <= (count_nxt == FULL_CNT);
    end
  end

  // Word storage; no reset needed since nothing reads an empty slot.
  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

  chk_fifo_ready_flag: assert property (@(posedge clk) disable iff (!rst_n)
    in_ready == (count_r != FULL_CNT))
    else $error("fifo ready disagrees with occupancy");

endmodule : bsr_fifo
`default_nettype wire

/* core/bsr_pkg.sv */
// What this block does
// RULE1: Each instance has a bit/word mode setting; after reset it is bit mode.
// RULE2: Bit mode forward edge shifts fields upward and loads the forward bit into field one.
// RULE3: Bit mode backward edge shifts fields downward and loads the backward bit into field eight.
// RULE4: Bit mode shows the eight single-bit fields as eight separate output contacts.
// RULE5: A wipe request while the instance is active sets every field to zero.
// RULE6: Shifts and wipes act only while the activate coil is on; otherwise fields hold.
// RULE7: Word mode inputs and fields hold signed 32-bit two's-complement values.
// RULE8: Only in word mode are the eight word outputs driven with fields one to eight.
// RULE9: Bit mode ignores both word inputs and leaves the word outputs undriven (zero).
// RULE10: Up to thirty-two independent instances, each with fields, coils and mode.
// RULE11: Word mode forward edge shifts fields upward and loads the forward word into field one.
// RULE12: Word mode backward edge shifts fields downward and loads the backward word into field eight.
// RULE13: Rising edges come from comparing each pulse level with the previous scan's level.
// RULE14: A wipe in the same scan as a shift edge wins and leaves all fields zero.
package bsr_pkg;

  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int BSR_FIELDS     = 8;
  localparam int BSR_WORD_W     = 32;
  localparam int BSR_FLAT_W     = BSR_FIELDS * BSR_WORD_W;
  localparam int BSR_INST_MAX   = 32;
  localparam int BSR_INST_W     = 5;
  localparam int BSR_FIFO_DEPTH = 8;

  // ****************************************************************
  // Layout of one queued scan sample
  // ****************************************************************
  localparam int BSR_POS_FWD_WORD = 0;
  localparam int BSR_POS_BWD_WORD = 32;
  localparam int BSR_POS_ACT      = 64;
  localparam int BSR_POS_WIPE     = 65;
  localparam int BSR_POS_FWD_LVL  = 66;
  localparam int BSR_POS_BWD_LVL  = 67;
  localparam int BSR_POS_FWD_BIT  = 68;
  localparam int BSR_POS_BWD_BIT  = 69;
  localparam int BSR_POS_INST     = 70;
  localparam int BSR_SCAN_W       = 75;

  // ****************************************************************
  // Operating mode
  // ****************************************************************
  typedef enum logic {BSR_MODE_BIT, BSR_MODE_WORD} bsr_mode_t;
  localparam bsr_mode_t BSR_MODE_RESET = BSR_MODE_BIT;
  localparam logic      BSR_LVL_RESET  = 1'b0;

endpackage : bsr_pkg

/* dv/bidir_eight_stage_shift_register_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module bidir_eight_stage_shift_register_tb
  import bsr_pkg::*;
();
  logic         clk = 0;
  logic         rst_n = 0;
  logic         scan_valid, scan_ready, mode_set, dwm, res_valid, res_ready, res_mode, live;
  logic [4:0]   scan_inst, mode_inst, res_inst;
  logic [5:0]   coils;
  logic [31:0]  fw, bw;
  logic [7:0]   bits;
  logic [255:0] words;
  int           err_count = 0;
  int           compares = 0;

  // ****************************************************************
  // Clock, design and user logic
  // ****************************************************************
  always #5 clk = ~clk;

  bsr_core i_dut (.clk(clk), .rst_n(rst_n), .scan_valid(scan_valid), .scan_ready(scan_ready),
    .scan_inst(scan_inst), .block_activate_coil(coils[5]), .field_wipe_coil(coils[4]),
    .forward_shift_pulse(coils[3]), .backward_shift_pulse(coils[2]), .forward_bit_input(coils[1]),
    .backward_bit_input(coils[0]), .forward_word_input(fw), .backward_word_input(bw),
    .mode_set(mode_set), .mode_set_inst(mode_inst), .double_word_mode(dwm), .res_valid(res_valid),
    .res_ready(res_ready), .res_inst(res_inst), .res_word_mode(res_mode), .bit_field_outputs(bits),
    .word_field_outputs(words), .word_outputs_live(live));

  bsr_user_model u_user (.clk(clk), .scan_valid(scan_valid), .scan_ready(scan_ready),
    .scan_inst(scan_inst), .coils(coils), .fw(fw), .bw(bw), .mode_set(mode_set), .mode_inst(mode_inst),
    .dwm(dwm), .res_valid(res_valid), .res_ready(res_ready), .res_inst(res_inst), .res_mode(res_mode),
    .live(live), .bits(bits), .words(words));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic give_verdict();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : give_verdict

  // A wait that ran out is counted and ends the run.
  task automatic fail();
    err_count++;
    give_verdict();
  endtask : fail

  task automatic check(input string what, input logic [255:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check

  // Takes one result and compares every field of it.
  task automatic expect_res(input logic [4:0] i, input logic m, input logic [7:0] q, input logic [255:0] d);
    logic [4:0]   ri;
    logic         rm, rl;
    logic [7:0]   rq;
    logic [255:0] rd;
    bit           ok;
    u_user.take(ri, rm, rl, rq, rd, ok);
    if (!ok) fail();
    check("res_inst", ri, i);
    check("res_word_mode", rm, m);
    check("word_outputs_live", rl, m);
    check("bit_field_outputs", rq, q);
    check("word_field_outputs", rd, d);
  endtask : expect_res

  task automatic scan(input logic [4:0] i, input logic [5:0] c, input logic [31:0] f, b, input logic m,
                      input logic [7:0] q, input logic [255:0] d);
    bit ok;
    u_user.send(i, c, f, b, ok);
    u_user.idle();
    if (!ok) fail();
    expect_res(i, m, q, d);
  endtask : scan

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  // Bit forward; word inputs are busy but must not leak in.
  task automatic t_bit_fwd();
    scan(0, 6'b101010, 32'h1234, 32'h5678, 0, 8'h01, 0);
    scan(0, 6'b101010, 32'h1234, 32'h5678, 0, 8'h01, 0);
    scan(0, 6'b100000, 0, 0, 0, 8'h01, 0);
    scan(0, 6'b101000, 0, 0, 0, 8'h02, 0);
  endtask : t_bit_fwd

  // Bit backward, then inactive hold and wipe against a same-scan edge.
  task automatic t_bit_bwd();
    scan(1, 6'b100101, 0, 0, 0, 8'h80, 0);
    scan(1, 6'b100001, 0, 0, 0, 8'h80, 0);
    scan(1, 6'b100101, 0, 0, 0, 8'hc0, 0);
    scan(1, 6'b011010, 0, 0, 0, 8'hc0, 0);
    scan(1, 6'b100000, 0, 0, 0, 8'hc0, 0);
    scan(1, 6'b111010, 0, 0, 0, 8'h00, 0);
  endtask : t_bit_bwd

  // Word mode at both ends of the signed range.
  task automatic t_word();
    u_user.set_mode(2, 1);
    scan(2, 6'b101000, 32'h80000000, 0, 1, 0, 256'h80000000);
    scan(2, 6'b100000, 0, 0, 1, 0, 256'h80000000);
    scan(2, 6'b101000, 32'h7fffffff, 0, 1, 0, {32'h80000000, 32'h7fffffff});
    scan(2, 6'b100100, 0, 32'ha, 1, 0, {32'ha, 192'h0, 32'h80000000});
    // Back to bit mode: only bit zero of each field survives, and the word inputs are ignored.
    u_user.set_mode(2, 0);
    scan(2, 6'b101010, 32'h5, 0, 0, 8'h01, 0);
    scan(0, 6'b100000, 0, 0, 0, 8'h02, 0);
  endtask : t_word

  // Results are held back until the queue refuses, then drained back to back; the forward
  // pulse stays high over pairs of scans so that a held level meets back-to-back evaluation.
  task automatic t_fifo();
    bit ok;
    u_user.stall();
    fork
      begin
        for (int k = 0; k < 12; k++) begin
          u_user.send(5'd31, {2'b10, ~k[1], 3'b010}, 0, 0, ok);
          if (!ok) fail();
        end
        u_user.idle();
      end
      begin
        repeat (20) @(posedge clk);
        #1;
        check("scan_ready", scan_ready, 1'b0);
        for (int k = 0; k < 12; k++) begin
          expect_res(5'd31, 0, 8'hff >> (7 - k / 4), 0);
        end
      end
    join
  endtask : t_fifo

  // Reset, then each scenario in turn.
  initial begin
    repeat (8) @(posedge clk);
    #1;
    rst_n = 1;
    t_bit_fwd();
    t_bit_bwd();
    t_word();
    t_fifo();
    give_verdict();
  end
endmodule : bidir_eight_stage_shift_register_tb
`default_nettype wire

/* dv/bsr_user_model.sv */
`timescale 1ns/1ns
`default_nettype none
module bsr_user_model
  import bsr_pkg::*;
(
  // Clock
  input  wire logic          clk,
  // Scan side, coils are {act, wipe, fwd, bwd, fwd bit, bwd bit}
  output logic               scan_valid,
  input  wire logic          scan_ready,
  output logic [4:0]         scan_inst,
  output logic [5:0]         coils,
  output logic [31:0]        fw,
  output logic [31:0]        bw,
  // Mode side
  output logic               mode_set,
  output logic [4:0]         mode_inst,
  output logic               dwm,
  // Result side
  input  wire logic          res_valid,
  output logic               res_ready,
  input  wire logic [4:0]    res_inst,
  input  wire logic          res_mode,
  input  wire logic          live,
  input  wire logic [7:0]    bits,
  input  wire logic [255:0]  words
);
  // Idle levels at time zero; nothing is offered before the bench asks.
  initial begin
    {scan_valid, scan_inst, coils, fw, bw, mode_set, mode_inst, dwm, res_ready} = '0;
  end

  // Offer one scan and hold it until the edge that takes it.
  task automatic send(input logic [4:0] i, input logic [5:0] c, input logic [31:0] f, b, output bit ok);
    ok = 0;
    scan_valid = 1;
    scan_inst = i;
    coils = c;
    fw = f;
    bw = b;
    for (int n = 0; n < 40 && !ok; n++) begin
      ok = scan_ready;
      @(posedge clk);
      #1;
    end
  endtask : send

  // Released lines show a changed pattern, so stale data cannot pass.
  task automatic idle();
    scan_valid = 0;
    scan_inst = ~scan_inst;
    coils = ~coils;
    fw = ~fw;
    bw = ~bw;
  endtask : idle

  // One-cycle mode write.
  task automatic set_mode(input logic [4:0] i, input logic m);
    mode_set = 1;
    mode_inst = i;
    dwm = m;
    @(posedge clk);
    #1;
    mode_set = 0;
  endtask : set_mode

  // Ready stays high after a take; the bench lowers it to stall.
  task automatic take(output logic [4:0] i, output logic m, l, output logic [7:0] q, output logic [255:0] d,
                      output bit ok);
    ok = 0;
    res_ready = 1;
    for (int n = 0; n < 60 && !ok; n++) begin
      ok = res_valid;
      if (!ok) begin
        @(posedge clk);
        #1;
      end
    end
    {i, m, l, q, d} = {res_inst, res_mode, live, bits, words};
    @(posedge clk);
    #1;
  endtask : take

  task automatic stall();
    res_ready = 0;
  endtask : stall
endmodule : bsr_user_model
`default_nettype wire
